// File: hw/bsp_pkg.sv
// constants shared by both ends of the two-word burst sram port
// assumes one 250 mhz system clock on each end
package bsp_pkg;
  // ----------------------------------------
  // widths and organisation
  // ----------------------------------------
  localparam int DATA_W = 18; // narrow variant word width
  localparam int ADDR_W = 20; // words per array, log2
  localparam int LANE_W = 9; // bits covered by one byte write select
  localparam int BURST_LEN = 2; // words per loaded address
  localparam int FIFO_DEPTH = 8; // host command queue depth
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_MHZ = 250; // system clock rate
  localparam int PLL_OFF_MAX_MHZ = 167; // top input clock rate with pll off
  localparam int LAT_PLL_ON = 2; // read latency in input clock cycles
  localparam int LAT_PLL_OFF = 1; // older single cycle latency
  localparam int K_HALF = 4; // system cycles per input clock half period
  // least half period allowed with the pll off, rounded up
  localparam int K_HALF_MIN_OFF = (CLK_MHZ + 2 * PLL_OFF_MAX_MHZ - 1) / (2 * PLL_OFF_MAX_MHZ);
  localparam int K_SETUP = 2; // cycles the host presents pins before an edge
endpackage

// File: hw/bsp_link_if.sv
// pin level link between memory controller and sram device
// assumes both ends on one clock; resolves the shared data bus here
`timescale 1ns/10ps
`default_nettype none
interface bsp_link_if #(
  parameter int W = bsp_pkg::DATA_W,
  parameter int AW = bsp_pkg::ADDR_W
);
  localparam int NB = W / bsp_pkg::LANE_W;
  logic k; // true input clock
  logic k_n; // complementary input clock
  logic load_strobe_n; // starts a bus cycle, low active
  logic rw; // high read, low write
  logic pll_disable_n; // low selects single cycle latency
  logic [AW-1:0] addr; // shared address
  logic [NB-1:0] byte_write_select_n; // low writes the lane
  logic [W-1:0] dq_h; // host drive value
  logic dq_h_oe_n; // host enable, low drives
  logic [W-1:0] dq_d; // device drive value
  logic dq_d_oe_n; // device enable, low drives
  logic echo_clock; // free running echo
  logic echo_clock_n; // complementary echo
  logic output_valid_flag; // read data valid
  wire [W-1:0] dq; // resolved data wire
  // device wins if both drive; a correct host never lets that happen
  // a released bus shows the inverse of the device's last word, so stale data never looks fresh
  assign dq = !dq_d_oe_n ? dq_d : (!dq_h_oe_n ? dq_h : ~dq_d);
  modport dev (
    input k, k_n, load_strobe_n, rw, pll_disable_n, addr, byte_write_select_n, dq,
    output dq_d, dq_d_oe_n, echo_clock, echo_clock_n, output_valid_flag
  );
  modport host (
    output k, k_n, load_strobe_n, rw, pll_disable_n, addr, byte_write_select_n, dq_h, dq_h_oe_n,
    input dq, echo_clock, echo_clock_n, output_valid_flag
  );
endinterface
`default_nettype wire

// File: hw/bsp_device.sv
// sram device end of the burst port: capture, arrays, read launch
// assumes pins arrive unsynchronised; input clocks are sampled, not used as clocks
//
// Summary of operation
// - write data taken on both clock edges
// - read words launched on both edges
// - data outputs released when not reading
// - low load strobe at true edge starts
// - every access moves exactly two words
// - byte selects sampled with their word
// - deselected bytes keep stored value
// - each select covers nine data bits
// - one shared address bus sampled
// - storage split into two equal arrays
// - direction high reads, low writes
// - valid flag high while read data out
// - accesses start on true clock edge
// - complementary edge captures and launches too
// - free running echo clocks follow input
// - pll off gives older single latency
`timescale 1ns/10ps
`default_nettype none
module bsp_device #(
  parameter int W = bsp_pkg::DATA_W,
  parameter int AW = bsp_pkg::ADDR_W
) (
  input wire logic clk,
  input wire logic rstn,
  bsp_link_if.dev bus,
  output logic pll_on
);
  localparam int NB = W / bsp_pkg::LANE_W;
  localparam int SW = 5 + AW + NB + W;

  // ----------------------------------------
  // lane merge
  // ----------------------------------------
  // keeps old lanes whose select is high
  function automatic logic [W-1:0] merge(input logic [W-1:0] old_w, input logic [W-1:0] new_w,
                                         input logic [NB-1:0] sel_n);
    logic [W-1:0] res;
    res = old_w;
    for (int i = 0; i < NB; i++) begin
      // lane i spans bits i*9 .. i*9+8
      if (!sel_n[i]) begin
        res[i*bsp_pkg::LANE_W +: bsp_pkg::LANE_W] = new_w[i*bsp_pkg::LANE_W +: bsp_pkg::LANE_W];
      end
    end
    return res;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [SW-1:0] pin_raw; // all inputs bundled
  logic [SW-1:0] pin_s1_r; // first stage, read only by second
  logic [SW-1:0] pin_s2_r; // safe copy
  logic k_d_r; // delayed true clock for edge find
  logic kn_d_r; // delayed complementary clock
  // idle pin levels, so no false clock edge or load follows reset
  localparam logic [SW-1:0] PIN_IDLE = {1'b1, 1'b0, 1'b1, 1'b1, 1'b1, {AW{1'b0}}, {NB{1'b1}}, {W{1'b0}}};
  assign pin_raw = {bus.k, bus.k_n, bus.load_strobe_n, bus.rw, bus.pll_disable_n,
                    bus.addr, bus.byte_write_select_n, bus.dq};

  // two stage capture of every pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_s1_r <= PIN_IDLE;
      pin_s2_r <= PIN_IDLE;
      k_d_r <= 1'b1;
      kn_d_r <= 1'b0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      k_d_r <= pin_s2_r[SW-1];
      kn_d_r <= pin_s2_r[SW-2];
    end
  end

  logic k_s, kn_s, load_n_s, rw_s, pll_s; // synced controls
  logic [AW-1:0] addr_s; // synced address
  logic [NB-1:0] sel_n_s; // synced byte selects
  logic [W-1:0] dq_s; // synced data
  assign {k_s, kn_s, load_n_s, rw_s, pll_s, addr_s, sel_n_s, dq_s} = pin_s2_r;

  logic k_rise; // true clock rising edge seen
  logic kn_rise; // complementary clock rising edge seen
  assign k_rise = k_s & ~k_d_r;
  assign kn_rise = kn_s & ~kn_d_r;

  // ----------------------------------------
  // command decode
  // ----------------------------------------
  logic rd_load; // read loaded at this true edge
  logic wr_load; // write loaded at this true edge
  assign rd_load = k_rise & ~load_n_s & rw_s;
  assign wr_load = k_rise & ~load_n_s & ~rw_s;

  // latency mode follows the synced pll pin
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pll_on <= 1'b1;
    end else begin
      pll_on <= pll_s;
    end
  end

  // ----------------------------------------
  // storage
  // ----------------------------------------
  // two equal arrays
  logic [W-1:0] mem0 [0:(1<<AW)-1]; // first burst word
  logic [W-1:0] mem1 [0:(1<<AW)-1]; // second burst word
  logic wr_pend_r; // second write word still owed
  logic [AW-1:0] wr_a_r; // held write address

  // write sequencer, second word on complementary edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_pend_r <= 1'b0;
      wr_a_r <= '0;
    end else if (wr_load) begin
      wr_pend_r <= 1'b1;
      wr_a_r <= addr_s;
    end else if (kn_rise || k_rise) begin
      wr_pend_r <= 1'b0;
    end
  end

  // array writes, self timed on the sampled edge
  always_ff @(posedge clk) begin
    if (wr_load) begin
      mem0[addr_s] <= merge(mem0[addr_s], dq_s, sel_n_s);
    end
    if (kn_rise && wr_pend_r) begin
      mem1[wr_a_r] <= merge(mem1[wr_a_r], dq_s, sel_n_s);
    end
  end

  // ----------------------------------------
  // read pipeline
  // ----------------------------------------
  logic [1:0] rd_v_r; // read in flight per true edge stage
  logic [AW-1:0] rd_a0_r; // stage 0 address
  logic [AW-1:0] rd_a1_r; // stage 1 address
  logic launch_v; // a read leaves at this true edge
  logic [AW-1:0] launch_a; // its address
  assign launch_v = pll_on ? rd_v_r[1] : rd_v_r[0];
  assign launch_a = pll_on ? rd_a1_r : rd_a0_r;

  // stage shift on every true edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rd_v_r <= 2'h0;
      rd_a0_r <= '0;
      rd_a1_r <= '0;
    end else if (k_rise) begin
      rd_v_r <= {rd_v_r[0], rd_load};
      rd_a0_r <= addr_s;
      rd_a1_r <= rd_a0_r;
    end
  end

  // ----------------------------------------
  // output drive
  // ----------------------------------------
  logic [W-1:0] dq_o_r; // driven data
  logic oe_n_r; // device data enable, low drives
  logic vld_r; // valid flag
  logic drv2_r; // second word due on complementary edge
  logic [AW-1:0] drv_a_r; // address of word in flight

  // launch on both edges
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dq_o_r <= '0;
      oe_n_r <= 1'b1;
      vld_r <= 1'b0;
      drv2_r <= 1'b0;
      drv_a_r <= '0;
    end else if (k_rise) begin
      if (launch_v) begin
        dq_o_r <= mem0[launch_a];
        oe_n_r <= 1'b0;
        vld_r <= 1'b1;
        drv2_r <= 1'b1;
        drv_a_r <= launch_a;
      end else begin
        oe_n_r <= 1'b1;
        vld_r <= 1'b0;
        drv2_r <= 1'b0;
      end
    end else if (kn_rise && drv2_r) begin
      dq_o_r <= mem1[drv_a_r];
      drv2_r <= 1'b0;
    end
  end

  // ----------------------------------------
  // echo clocks
  // ----------------------------------------
  logic echo_r; // echo follows synced true clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      echo_r <= 1'b0;
    end else begin
      echo_r <= k_s;
    end
  end

  // echo edges and data change on the same system edge
  assign bus.echo_clock = echo_r;
  assign bus.echo_clock_n = ~echo_r;
  assign bus.output_valid_flag = vld_r;
  assign bus.dq_d = dq_o_r;
  assign bus.dq_d_oe_n = oe_n_r;
endmodule
`default_nettype wire

// File: hw/bsp_host.sv
// memory controller end of the burst port, with its command queue
// assumes one system clock; it makes the input clocks by division
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// command queue
// ----------------------------------------
module bsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = bsp_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [0:DEPTH-1]; // entries
  logic [PW-1:0] wp_r; // write pointer
  logic [PW-1:0] rp_r; // read pointer
  logic [PW:0] cnt_r; // fill count
  logic push, pop; // accepted moves
  assign in_ready = (cnt_r != (PW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign out_data = store[rp_r];

  // pointers and count
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
      end
      cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // entry storage
  always_ff @(posedge clk) begin
    if (push) begin
      store[wp_r] <= in_data;
    end
  end
endmodule

// ----------------------------------------
// controller
// ----------------------------------------
module bsp_host #(
  parameter int W = bsp_pkg::DATA_W,
  parameter int AW = bsp_pkg::ADDR_W,
  parameter int HALF = bsp_pkg::K_HALF
) (
  input wire logic clk,
  input wire logic rstn,
  bsp_link_if.host bus,
  input wire logic pll_enable,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_rw,
  input wire logic [AW-1:0] cmd_addr,
  input wire logic [W-1:0] cmd_wdata0,
  input wire logic [W-1:0] cmd_wdata1,
  input wire logic [W/bsp_pkg::LANE_W-1:0] cmd_sel0_n,
  input wire logic [W/bsp_pkg::LANE_W-1:0] cmd_sel1_n,
  output logic rd_valid,
  output logic [W-1:0] rd_data0,
  output logic [W-1:0] rd_data1
);
  localparam int NB = W / bsp_pkg::LANE_W;
  localparam int CW = $clog2(2 * HALF);
  localparam int FW = 1 + AW + 2 * W + 2 * NB;

  // ----------------------------------------
  // input clock generation
  // ----------------------------------------
  logic [CW-1:0] cnt_r; // phase within one input clock period
  logic k_r, kn_r; // driven clocks
  logic prep_k, prep_kn; // load pins for the coming edge
  assign prep_k = (cnt_r == CW'(2 * HALF - 1 - bsp_pkg::K_SETUP));
  assign prep_kn = (cnt_r == CW'(HALF - 1 - bsp_pkg::K_SETUP));

  // divider
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
      k_r <= 1'b1;
      kn_r <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == CW'(2 * HALF - 1)) ? '0 : cnt_r + 1'b1;
      if (cnt_r == CW'(2 * HALF - 1)) begin
        k_r <= 1'b1;
        kn_r <= 1'b0;
      end else if (cnt_r == CW'(HALF - 1)) begin
        k_r <= 1'b0;
        kn_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // queue and issue
  // ----------------------------------------
  logic q_v, q_rdy; // queue output handshake
  logic [FW-1:0] q_d; // queue output entry
  logic e_rw; // entry fields
  logic [AW-1:0] e_a;
  logic [W-1:0] e_w0, e_w1;
  logic [NB-1:0] e_b0, e_b1;
  assign {e_rw, e_a, e_w0, e_w1, e_b0, e_b1} = q_d;

  bsp_fifo #(.WIDTH(FW), .DEPTH(bsp_pkg::FIFO_DEPTH)) u_q (
    .clk(clk),
    .rstn(rstn),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .in_data({cmd_rw, cmd_addr, cmd_wdata0, cmd_wdata1, cmd_sel0_n, cmd_sel1_n}),
    .out_valid(q_v),
    .out_ready(q_rdy),
    .out_data(q_d)
  );

  logic pll_r; // latency mode, also drives the pin
  logic [2:0] rd_hist_r; // reads issued one, two, three slots back
  logic wr_block; // device may own the bus in this slot
  // no write while a read burst may be on the bus
  assign wr_block = pll_r ? (|rd_hist_r) : (|rd_hist_r[1:0]);
  // stalls hold entries in the queue, so it really fills
  assign q_rdy = prep_k & (e_rw | ~wr_block);

  logic load_n_r, rw_r, oe_n_r, w2_r; // pin state
  logic [AW-1:0] a_r;
  logic [W-1:0] dq_r, w1_r;
  logic [NB-1:0] sel_r, b1_r;

  // pin sequencing per slot
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pll_r <= 1'b1;
      rd_hist_r <= 3'h0;
      load_n_r <= 1'b1;
      rw_r <= 1'b1;
      oe_n_r <= 1'b1;
      w2_r <= 1'b0;
      a_r <= '0;
      dq_r <= '0;
      w1_r <= '0;
      sel_r <= '1;
      b1_r <= '1;
    end else if (prep_k) begin
      pll_r <= pll_enable;
      load_n_r <= ~(q_v & q_rdy);
      rw_r <= e_rw;
      a_r <= e_a;
      rd_hist_r <= {rd_hist_r[1:0], q_v & q_rdy & e_rw};
      oe_n_r <= ~(q_v & q_rdy & ~e_rw);
      w2_r <= q_v & q_rdy & ~e_rw;
      dq_r <= e_w0;
      sel_r <= e_b0;
      w1_r <= e_w1;
      b1_r <= e_b1;
    end else if (prep_kn) begin
      // second word for the complementary edge
      oe_n_r <= ~w2_r;
      w2_r <= 1'b0;
      dq_r <= w1_r;
      sel_r <= b1_r;
    end
  end

  assign bus.k = k_r;
  assign bus.k_n = kn_r;
  assign bus.load_strobe_n = load_n_r;
  assign bus.rw = rw_r;
  assign bus.addr = a_r;
  assign bus.dq_h = dq_r;
  assign bus.dq_h_oe_n = oe_n_r;
  assign bus.byte_write_select_n = sel_r;
  assign bus.pll_disable_n = pll_r;

  // ----------------------------------------
  // read capture on echo edges
  // ----------------------------------------
  logic [W+2:0] e_s1_r, e_s2_r; // echo, echo_n, valid, data synchronisers
  logic ec_d_r, ecn_d_r; // delayed echoes
  logic got0_r; // first word held
  logic ec_rise, ecn_rise, v_s;
  logic [W-1:0] d_s;
  assign {v_s, d_s} = e_s2_r[W:0];
  assign ec_rise = e_s2_r[W+2] & ~ec_d_r;
  assign ecn_rise = e_s2_r[W+1] & ~ecn_d_r;

  // syncs and word pairing
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      e_s1_r <= '0;
      e_s2_r <= '0;
      ec_d_r <= 1'b0;
      ecn_d_r <= 1'b0;
      got0_r <= 1'b0;
      rd_valid <= 1'b0;
      rd_data0 <= '0;
      rd_data1 <= '0;
    end else begin
      e_s1_r <= {bus.echo_clock, bus.echo_clock_n, bus.output_valid_flag, bus.dq};
      e_s2_r <= e_s1_r;
      ec_d_r <= e_s2_r[W+2];
      ecn_d_r <= e_s2_r[W+1];
      rd_valid <= 1'b0;
      if (ec_rise) begin
        // first word on the true echo edge
        got0_r <= v_s;
        rd_data0 <= d_s;
      end else if (ecn_rise && got0_r && v_s) begin
        // second word completes the burst
        got0_r <= 1'b0;
        rd_data1 <= d_s;
        rd_valid <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: test/bsp_link_asserts.sv
// checker for the pin level link between the controller and sram ends
// assumes one clock, rstn active low, inputs taken straight off the link interface
`timescale 1ns/10ps
`default_nettype none
module bsp_link_asserts #(
  parameter int HALF = bsp_pkg::K_HALF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic k,
  input wire logic load_strobe_n,
  input wire logic rw,
  input wire logic pll_disable_n,
  input wire logic dq_h_oe_n,
  input wire logic dq_d_oe_n,
  input wire logic echo_clock,
  input wire logic echo_clock_n,
  input wire logic output_valid_flag
);
  // ----------------------------------------
  // helper logic
  // ----------------------------------------
  localparam int D_ON = 2 * bsp_pkg::LAT_PLL_ON * HALF + 3; // load edge to first word, pll on
  localparam int D_OFF = 2 * bsp_pkg::LAT_PLL_OFF * HALF + 3; // load edge to first word, pll off
  logic [2:0] age_r; // cycles since reset, saturating
  // age counter keeps the echo follow check off the sync flops' reset values
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      age_r <= 3'h0;
    end else if (age_r != 3'h7) begin
      age_r <= age_r + 3'h1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // ----------------------------------------
  // sequences and properties
  // ----------------------------------------
  sequence s_rd_load;
    $rose(k) && !load_strobe_n && rw;
  endsequence
  sequence s_launch;
    output_valid_flag && $rose(echo_clock);
  endsequence
  property p_lat_on;
    s_rd_load ##0 pll_disable_n |-> ##D_ON s_launch;
  endproperty
  property p_lat_off;
    s_rd_load ##0 !pll_disable_n |-> ##D_OFF s_launch;
  endproperty
  property p_echo_follow;
    age_r == 3'h7 |-> echo_clock == $past(k, 3);
  endproperty
  property p_echo_pair;
    echo_clock_n == !echo_clock;
  endproperty
  property p_valid_drive;
    output_valid_flag == !dq_d_oe_n;
  endproperty
  property p_valid_rise;
    $rose(output_valid_flag) |-> $rose(echo_clock);
  endproperty
  property p_valid_burst;
    $rose(output_valid_flag) |-> output_valid_flag [*8];
  endproperty
  property p_release;
    $fell(output_valid_flag) |-> $rose(echo_clock) && dq_d_oe_n;
  endproperty
  property p_no_clash;
    !(!dq_d_oe_n && !dq_h_oe_n);
  endproperty
  property p_wr_drive;
    $rose(k) && !load_strobe_n && !rw |-> !dq_h_oe_n;
  endproperty
  a_lat_on: assert property (p_lat_on) else $error("read word late or early, pll on");
  a_lat_off: assert property (p_lat_off) else $error("read word late or early, pll off");
  a_echo_follow: assert property (p_echo_follow) else $error("echo clock not tracking k");
  a_echo_pair: assert property (p_echo_pair) else $error("echo pair not complementary");
  a_valid_drive: assert property (p_valid_drive) else $error("valid flag and drive differ");
  a_valid_rise: assert property (p_valid_rise) else $error("valid rose off echo edge");
  a_valid_burst: assert property (p_valid_burst) else $error("valid shorter than two words");
  a_release: assert property (p_release) else $error("data bus released off echo edge");
  a_no_clash: assert property (p_no_clash) else $error("both ends drive the data bus");
  a_wr_drive: assert property (p_wr_drive) else $error("write word missing at load edge");
endmodule
`default_nettype wire

// File: test/burst_sram_port_bench.sv
// self-checking bench: controller and sram ends joined by the link interface
// assumes a 250 mhz clk and an address space shrunk to 6 bits
`timescale 1ns/10ps
`default_nettype none
module burst_sram_port_bench;
  localparam int AW = 6; // shrunk address space
  logic clk, rstn, pll_enable, pll_on, cmd_valid, cmd_ready, cmd_rw, rd_valid, saw_full;
  logic [AW-1:0] cmd_addr, a;
  logic [17:0] cmd_wdata0, cmd_wdata1, rd_data0, rd_data1;
  logic [1:0] cmd_sel0_n, cmd_sel1_n;
  logic [17:0] mem0 [64]; // reference first array
  logic [17:0] mem1 [64]; // reference second array
  logic [35:0] exp_q [$]; // expected read pairs, oldest first
  int fails, n_compared, seed, n;
  // ----------------------------------------
  // design and checker
  // ----------------------------------------
  bsp_link_if #(.W(18), .AW(AW)) link ();
  bsp_host #(.W(18), .AW(AW), .HALF(bsp_pkg::K_HALF)) u_bsp_host (.clk(clk), .rstn(rstn), .bus(link.host),
    .pll_enable(pll_enable), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_rw(cmd_rw),
    .cmd_addr(cmd_addr), .cmd_wdata0(cmd_wdata0), .cmd_wdata1(cmd_wdata1), .cmd_sel0_n(cmd_sel0_n),
    .cmd_sel1_n(cmd_sel1_n), .rd_valid(rd_valid), .rd_data0(rd_data0), .rd_data1(rd_data1));
  bsp_device #(.W(18), .AW(AW)) u_bsp_device (.clk(clk), .rstn(rstn), .bus(link.dev), .pll_on(pll_on));
  bsp_link_asserts #(.HALF(bsp_pkg::K_HALF)) u_bsp_link_asserts (.clk(clk), .rstn(rstn), .k(link.k),
    .load_strobe_n(link.load_strobe_n), .rw(link.rw), .pll_disable_n(link.pll_disable_n),
    .dq_h_oe_n(link.dq_h_oe_n), .dq_d_oe_n(link.dq_d_oe_n), .echo_clock(link.echo_clock),
    .echo_clock_n(link.echo_clock_n), .output_valid_flag(link.output_valid_flag));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // verdict and end of run
  task automatic test_done;
    if (fails == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // one comparison, counted
  function automatic void check(input logic [35:0] got, input logic [35:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endfunction
  // lanes whose select is low take the new bits
  function automatic logic [17:0] merge(input logic [17:0] old, input logic [17:0] nw, input logic [1:0] sel_n);
    merge = old;
    for (int j = 0; j < 2; j++) begin
      if (!sel_n[j]) begin
        merge[9*j +: 9] = nw[9*j +: 9];
      end
    end
  endfunction
  // one command, held until taken; notes the expected result
  task automatic issue(input logic rw, input logic [AW-1:0] ad, input logic [1:0] b0, input logic [1:0] b1);
    logic [17:0] d0, d1;
    logic rdy;
    int w;
    d0 = 18'($random(seed));
    d1 = 18'($random(seed));
    cmd_valid <= 1'b1;
    cmd_rw <= rw;
    cmd_addr <= ad;
    cmd_wdata0 <= d0;
    cmd_wdata1 <= d1;
    cmd_sel0_n <= b0;
    cmd_sel1_n <= b1;
    rdy = 1'b0;
    w = 0;
    // ready is looked at mid cycle, where it has settled
    while (rdy !== 1'b1 && w < 2000) begin
      @(negedge clk);
      rdy = cmd_ready;
      if (rdy !== 1'b1) begin
        saw_full = 1'b1;
      end
      @(posedge clk);
      w++;
    end
    if (rdy !== 1'b1) begin
      fails++;
    end
    if (rw) begin
      exp_q.push_back({mem0[ad], mem1[ad]});
    end else begin
      mem0[ad] = merge(mem0[ad], d0, b0);
      mem1[ad] = merge(mem1[ad], d1, b1);
    end
  endtask
  // ----------------------------------------
  // clock, monitor, watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // read results against the oldest note
  always @(posedge clk) begin
    if (rstn === 1'b1 && rd_valid === 1'b1) begin
      check({rd_data0, rd_data1}, (exp_q.size() != 0) ? exp_q.pop_front() : {36{1'bx}});
    end
  end
  // hang guard
  initial begin
    repeat (40000) @(posedge clk);
    fails++;
    test_done();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    seed = 99490;
    fails = 0;
    n_compared = 0;
    saw_full = 1'b0;
    rstn = 1'b0;
    pll_enable = 1'b1;
    cmd_valid = 1'b0;
    cmd_rw = 1'b0;
    cmd_addr = 6'h00;
    cmd_wdata0 = 18'h00000;
    cmd_wdata1 = 18'h00000;
    cmd_sel0_n = 2'h3;
    cmd_sel1_n = 2'h3;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    // pass 0 with the pll on, pass 1 with it off
    for (int p = 0; p < 2; p++) begin
      pll_enable <= (p == 0);
      repeat (20) @(posedge clk);
      check({35'h0, pll_on}, {35'h0, pll_enable});
      for (int i = 0; i < 12; i++) begin
        a = 6'($random(seed));
        issue(1'b0, a, 2'h0, 2'h0);
        issue(1'b0, a, 2'(i % 4), 2'(i / 3));
        issue(1'b1, a, 2'h3, 2'h3);
      end
      cmd_valid <= 1'b0;
      n = 0;
      while (exp_q.size() != 0 && n < 5000) begin
        @(posedge clk);
        n++;
      end
      repeat (40) @(posedge clk);
    end
    check({35'h0, saw_full}, 36'h000000001);
    check(36'(exp_q.size()), 36'h000000000);
    test_done();
  end
endmodule
`default_nettype wire
